// [wdsv_pkg.sv]
package wdsv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, as seen on the special-function register port
  localparam logic [7:0] WDSV_RESTART_ADDR = 8'hA6; // watchdog_restart, wo
  localparam logic [7:0] WDSV_PERIOD_ADDR = 8'hA7; // watchdog_period
  localparam int WDSV_PERIOD_LSB = 0; // period_select field position
  localparam int WDSV_PERIOD_W = 3; // period_select field width
  localparam logic [2:0] WDSV_PERIOD_RESET = 3'h0; // shortest time-out
  localparam logic [7:0] WDSV_RESTART_READ = 8'h00; // write-only answer

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence bytes
  localparam logic [7:0] WDSV_UNLOCK_FIRST = 8'h1E;
  localparam logic [7:0] WDSV_UNLOCK_SECOND = 8'hE1;

  ////////////////////////////////////////////////////////////////////////////
  // counter structure and timing
  localparam int WDSV_PRESCALE_W = 14; // prescaler width
  localparam int WDSV_COUNT_W = 7; // programmable counter width
  localparam int WDSV_CHAIN_W = WDSV_PRESCALE_W + WDSV_COUNT_W;
  localparam int WDSV_PHASE_DIV = 6; // watchdog clocks per prescaler step
  localparam int WDSV_REF_CLK_HZ = 20_000_000; // ref_clk is the oscillator
  localparam int WDSV_OSC_HZ = 20_000_000;
  localparam int WDSV_RST_PULSE_OSC = 96; // pulse length, oscillator periods
  localparam int WDSV_RST_PULSE_CYC =
    WDSV_RST_PULSE_OSC * (WDSV_REF_CLK_HZ / WDSV_OSC_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence tracker
  typedef enum logic {WDSV_SEQ_IDLE, WDSV_SEQ_GOT_FIRST} wdsv_seq_e;

endpackage : wdsv_pkg

// [wdsv_ctl_if.sv]
`timescale 1ns/1ps
// signals shared between the watchdog core and its two helpers
interface wdsv_ctl_if;
  logic run; // watchdog clock may advance
  logic clear; // restart, overflow or disarm: zero the phase divider
  logic halfrate_sel; // force oscillator/2
  logic double_speed; // double-speed core mode
  logic tick; // one prescaler step, one-cycle pulse
  logic fire; // overflow: launch the reset pulse
  logic busy; // reset pulse in progress

  modport core (output run, clear, halfrate_sel, double_speed, fire,
                input tick, busy);
  modport tick_gen (input run, clear, halfrate_sel, double_speed,
                    output tick);
  modport pulse (input fire, output busy);
endinterface : wdsv_ctl_if

// [wdsv_tick_gen.sv]
`timescale 1ns/1ps
// watchdog clock and divide-by-six phase stage
module wdsv_tick_gen
  import wdsv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  wdsv_ctl_if.tick_gen ctl
);

  logic half_ff; // toggles each oscillator cycle for the /2 clock
  logic [2:0] phase_ff; // counts watchdog clocks within one step
  logic wclk_en; // one watchdog clock period elapsed

  ////////////////////////////////////////////////////////////////////////////
  // half-rate phase, held while stopped so power-down keeps its place
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || ctl.clear)
      half_ff <= 1'b0;
    else if (ctl.run)
      half_ff <= ~half_ff;
  end

  // halfrate select or standard mode gives osc/2, else full rate
  assign wclk_en = ctl.run &&
    ((ctl.halfrate_sel || !ctl.double_speed) ? half_ff : 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // six watchdog clocks make one prescaler step
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || ctl.clear)
      phase_ff <= 3'h0;
    else if (wclk_en)
      phase_ff <= (phase_ff == 3'(WDSV_PHASE_DIV - 1)) ? 3'h0 :
                  phase_ff + 3'h1;
  end

  assign ctl.tick = wclk_en && (phase_ff == 3'(WDSV_PHASE_DIV - 1));

endmodule : wdsv_tick_gen

// [wdsv_rst_pulse.sv]
`timescale 1ns/1ps
// stretches an overflow into the high chip-reset pulse
module wdsv_rst_pulse
  import wdsv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  wdsv_ctl_if.pulse ctl,
  output logic rst_pin
);

  logic [6:0] left_ff; // oscillator periods still to drive
  logic pin_ff; // reset pin level

  // pulse length must fit the 7-bit down-counter, refused at elaboration
  if (WDSV_RST_PULSE_CYC > 127 || WDSV_RST_PULSE_CYC < 1)
  begin : g_bad_pulse
    $error("reset pulse does not fit its counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // a fire during a pulse is ignored; the running pulse completes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      left_ff <= 7'h0;
      pin_ff <= 1'b0;
    end
    else if (ctl.fire && !pin_ff)
    begin
      left_ff <= 7'(WDSV_RST_PULSE_CYC - 1);
      pin_ff <= 1'b1;
    end
    else if (pin_ff)
    begin
      left_ff <= left_ff - 7'h1;
      pin_ff <= (left_ff != 7'h0);
    end
  end

  assign rst_pin = pin_ff;
  assign ctl.busy = pin_ff;

endmodule : wdsv_rst_pulse

// [wdsv_supervisor.sv]
`timescale 1ns/1ps
module wdsv_supervisor
  import wdsv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic wdog_clk_halfrate_sel,
  input wire logic double_speed_mode,
  input wire logic idle_mode,
  input wire logic power_down_mode,
  output logic wdog_rst_pin,
  output logic wdog_enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  wdsv_ctl_if ctl ();

  wdsv_seq_e seq_ff; // unlock sequence progress
  wdsv_seq_e nxt_seq;
  logic enable_ff; // watchdog armed
  logic [2:0] period_ff; // period_select field
  logic [WDSV_PRESCALE_W-1:0] pre_ff; // prescaler
  logic [WDSV_COUNT_W-1:0] cnt_ff; // programmable counter
  logic [WDSV_CHAIN_W-1:0] chain; // prescaler and counter as one value
  logic [7:0] rdata_ff; // registered read data
  logic wr_restart; // write strobe to the restart register
  logic wr_period; // write strobe to the period register
  logic restart; // sequence completed this cycle
  logic overflow; // time-out reached this cycle

  // last step value before overflow for a given period field
  function automatic logic [WDSV_CHAIN_W-1:0] limit_of(
    input logic [2:0] sel
  );
    logic [WDSV_CHAIN_W:0] full;
    full = (WDSV_CHAIN_W + 1)'(1) << (WDSV_PRESCALE_W + int'(sel));
    return WDSV_CHAIN_W'(full - (WDSV_CHAIN_W + 1)'(2));
  endfunction : limit_of

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign wr_restart = sfr_wr && (sfr_addr == WDSV_RESTART_ADDR);
  assign wr_period = sfr_wr && (sfr_addr == WDSV_PERIOD_ADDR);
  assign chain = {cnt_ff, pre_ff};

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence: any other byte starts detection over
  always_comb
  begin
    nxt_seq = seq_ff;
    restart = 1'b0;
    if (wr_restart)
    begin
      unique case (seq_ff)
        WDSV_SEQ_IDLE:
        begin
          // only the first unlock byte advances
          nxt_seq = (sfr_wdata == WDSV_UNLOCK_FIRST) ? WDSV_SEQ_GOT_FIRST :
                    WDSV_SEQ_IDLE;
        end
        WDSV_SEQ_GOT_FIRST:
        begin
          // second byte completes; a repeated first byte re-arms
          restart = (sfr_wdata == WDSV_UNLOCK_SECOND);
          nxt_seq = (sfr_wdata == WDSV_UNLOCK_FIRST) ? WDSV_SEQ_GOT_FIRST :
                    WDSV_SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      seq_ff <= WDSV_SEQ_IDLE;
    else
      seq_ff <= nxt_seq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable: set by the sequence, dropped only by reset or by overflow,
  // which itself is the chip reset being launched
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      enable_ff <= 1'b0;
    else if (restart)
      enable_ff <= 1'b1;
    else if (overflow)
      enable_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // period register; only the low field is stored, so stray ones in the
  // reserved bits cannot change the time-out
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      period_ff <= WDSV_PERIOD_RESET;
    else if (wr_period)
      period_ff <= sfr_wdata[WDSV_PERIOD_LSB +: WDSV_PERIOD_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data: reserved bits and the write-only register read as zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == WDSV_PERIOD_ADDR)
        rdata_ff <= {5'h00, period_ff};
      else
        rdata_ff <= WDSV_RESTART_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers: run stops in power-down or while disarmed; idle does not stop it
  assign ctl.run = enable_ff && !power_down_mode;
  assign ctl.clear = restart || overflow || !enable_ff;
  assign ctl.halfrate_sel = wdog_clk_halfrate_sel;
  assign ctl.double_speed = double_speed_mode;
  assign overflow = ctl.tick && (chain == limit_of(period_ff));
  assign ctl.fire = overflow;

  wdsv_tick_gen u_tick_gen (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl.tick_gen)
  );

  wdsv_rst_pulse u_rst_pulse (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ctl(ctl.pulse),
    .rst_pin(wdog_rst_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter chain; restart wins over a coincident tick
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pre_ff <= '0;
      cnt_ff <= '0;
    end
    else if (restart || overflow)
    begin
      pre_ff <= '0;
      cnt_ff <= '0;
    end
    else if (ctl.tick)
    begin
      // prescaler carry steps the programmable counter
      pre_ff <= pre_ff + 1'b1;
      if (&pre_ff)
        cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign wdog_enabled = enable_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] hi_len_ff; // length of the current reset pulse

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !wdog_rst_pin)
      hi_len_ff <= 8'h00;
    else if (hi_len_ff != 8'hFF)
      hi_len_ff <= hi_len_ff + 8'h01;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_reset_clear;
    $past(!rst_n) |-> !enable_ff && chain == '0 && period_ff == 3'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("watchdog not cleared by reset");

  property p_unlock;
    wr_restart && seq_ff == WDSV_SEQ_GOT_FIRST &&
      sfr_wdata == WDSV_UNLOCK_SECOND |=> enable_ff && chain == '0;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock sequence did not clear and enable");

  property p_stays_on;
    enable_ff && !overflow |=> enable_ff;
  endproperty
  a_stays_on: assert property (p_stays_on)
    else $error("watchdog disabled without reset");

  property p_pulse_len;
    $fell(wdog_rst_pin) |-> $past(hi_len_ff) == 8'd95;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse not 96 cycles");

  property p_pulse_start;
    overflow && !wdog_rst_pin |=> wdog_rst_pin[*8];
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("overflow did not raise reset pin");

  property p_slow_tick;
    ctl.tick && (wdog_clk_halfrate_sel || !double_speed_mode) |=>
      (!ctl.tick)[*8];
  endproperty
  a_slow_tick: assert property (p_slow_tick)
    else $error("half-rate tick spacing too short");

  property p_fast_tick;
    ctl.tick |=> (!ctl.tick)[*5];
  endproperty
  a_fast_tick: assert property (p_fast_tick)
    else $error("tick spacing below six clocks");

  property p_timeout;
    overflow |-> ctl.tick && chain == limit_of(period_ff) && enable_ff;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("overflow at wrong count");

  property p_idle_counts;
    idle_mode && ctl.tick && !overflow && !restart |=>
      chain == WDSV_CHAIN_W'($past(chain) + 1'b1);
  endproperty
  a_idle_counts: assert property (p_idle_counts)
    else $error("count did not advance in idle");

  property p_pd_hold;
    power_down_mode && !restart && !overflow |=> chain == $past(chain);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("count moved in power-down");

  property p_restart_read;
    sfr_rd && sfr_addr == WDSV_RESTART_ADDR |=> sfr_rdata == 8'h00;
  endproperty
  a_restart_read: assert property (p_restart_read)
    else $error("restart register read not zero");

  property p_period_read;
    sfr_rd && sfr_addr == WDSV_PERIOD_ADDR |=>
      sfr_rdata == {5'h00, $past(period_ff)};
  endproperty
  a_period_read: assert property (p_period_read)
    else $error("period read mismatch");

  property p_bad_byte;
    wr_restart && sfr_wdata != WDSV_UNLOCK_FIRST &&
      sfr_wdata != WDSV_UNLOCK_SECOND |=>
      seq_ff == WDSV_SEQ_IDLE && enable_ff == $past(enable_ff);
  endproperty
  a_bad_byte: assert property (p_bad_byte)
    else $error("stray byte affected watchdog");

  property p_pd_no_tick;
    power_down_mode |-> !ctl.tick;
  endproperty
  a_pd_no_tick: assert property (p_pd_no_tick)
    else $error("prescaler stepped in power-down");

  property p_one_pulse;
    ctl.busy |-> !overflow;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("overflow while reset pulse runs");

  c_unlock: cover property (restart);
  c_slow_tick: cover property (ctl.tick && wdog_clk_halfrate_sel);
  c_overflow: cover property (overflow);
  c_pd_resume: cover property (enable_ff && $fell(power_down_mode));

endmodule : wdsv_supervisor

// [wdsv_supervisor_tb.sv]
`timescale 1ns/1ps
// self-checking bench for the watchdog supervisor
module wdsv_supervisor_tb;
  import wdsv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // clock, limits and bench state
  localparam time HALF_PERIOD = 25ns; // 20 MHz reference clock
  localparam int CYC_LIMIT = 106000; // one full time-out plus margin
  localparam int PRE_PD_CYC = 300; // running time before power-down
  localparam int FREEZE_CYC = 1500; // power-down hold length
  logic ref_clk;
  logic rst_n;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic wdog_clk_halfrate_sel;
  logic double_speed_mode;
  logic idle_mode;
  logic power_down_mode;
  logic wdog_rst_pin;
  logic wdog_enabled;
  int err_total; // mismatches seen
  int tests_run; // comparisons made
  int cyc_cnt; // hang guard
  logic [7:0] rnd; // lfsr state
  logic [7:0] rdv; // last read value

  ////////////////////////////////////////////////////////////////////////////
  // design under test, every input driven by the bench
  wdsv_supervisor dut_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .wdog_clk_halfrate_sel(wdog_clk_halfrate_sel),
    .double_speed_mode(double_speed_mode),
    .idle_mode(idle_mode),
    .power_down_mode(power_down_mode),
    .wdog_rst_pin(wdog_rst_pin),
    .wdog_enabled(wdog_enabled)
  );

  ////////////////////////////////////////////////////////////////////////////
  // free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #HALF_PERIOD ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers: random source, verdict and comparisons
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // time-out in reference cycles for period code p and clock divisor d
  function automatic int exp_timeout(input int p, input int d);
    return d * WDSV_PHASE_DIV * ((1 << (WDSV_PRESCALE_W + p)) - 1);
  endfunction : exp_timeout

  task automatic complete_run;
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_byte

  // counts are bench values; a small window absorbs edge alignment
  task automatic chk_cnt(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, lo);
    end
  endtask : chk_cnt

  ////////////////////////////////////////////////////////////////////////////
  // register port cycles, launched on the falling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr_reg

  // data is registered, so it is taken one full cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    @(negedge ref_clk);
    d = sfr_rdata;
  endtask : rd_reg

  task automatic unlock;
    wr_reg(WDSV_RESTART_ADDR, WDSV_UNLOCK_FIRST);
    wr_reg(WDSV_RESTART_ADDR, WDSV_UNLOCK_SECOND);
    @(negedge ref_clk);
  endtask : unlock

  ////////////////////////////////////////////////////////////////////////////
  // hang guard: a run past the ceiling is a failure
  always @(posedge ref_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == CYC_LIMIT)
    begin
      err_total++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin : main_seq
    int n;
    int to_exp;
    err_total = 0;
    tests_run = 0;
    cyc_cnt = 0;
    rnd = 8'h26;
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    wdog_clk_halfrate_sel = 1'b0;
    double_speed_mode = 1'b0;
    idle_mode = 1'b0;
    power_down_mode = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    // reset state of outputs and registers
    chk_byte({6'h00, wdog_enabled, wdog_rst_pin}, 8'h00);
    rd_reg(WDSV_PERIOD_ADDR, rdv);
    chk_byte(rdv, 8'h00);
    rd_reg(WDSV_RESTART_ADDR, rdv);
    chk_byte(rdv, WDSV_RESTART_READ);
    // every period code, random junk in the reserved bits
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr_next(rnd);
      wdog_clk_halfrate_sel = rnd[0];
      double_speed_mode = rnd[1];
      idle_mode = rnd[2];
      wr_reg(WDSV_PERIOD_ADDR, {rnd[7:3], i[2:0]});
      rd_reg(WDSV_PERIOD_ADDR, rdv);
      chk_byte(rdv, {5'h00, i[2:0]});
    end
    // unmapped place: ignored on write, zero on read
    wr_reg(8'hA5, WDSV_UNLOCK_FIRST);
    rd_reg(8'hA5, rdv);
    chk_byte(rdv, 8'h00);
    // broken sequences must not arm the watchdog
    wr_reg(WDSV_RESTART_ADDR, WDSV_UNLOCK_SECOND);
    wr_reg(WDSV_RESTART_ADDR, WDSV_UNLOCK_FIRST);
    wr_reg(WDSV_RESTART_ADDR, 8'h5A);
    wr_reg(WDSV_RESTART_ADDR, WDSV_UNLOCK_SECOND);
    @(negedge ref_clk);
    chk_byte({7'h00, wdog_enabled}, 8'h00);
    // arm at the shortest period with the full-rate clock, idle on
    wr_reg(WDSV_PERIOD_ADDR, 8'h00);
    wdog_clk_halfrate_sel = 1'b0;
    double_speed_mode = 1'b1;
    idle_mode = 1'b1;
    unlock();
    chk_byte({7'h00, wdog_enabled}, 8'h01);
    // random register traffic cannot disarm it
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr_next(rnd);
      wr_reg(WDSV_PERIOD_ADDR, {5'h00, rnd[2:0]});
      wr_reg(WDSV_RESTART_ADDR, rnd | 8'h40);
    end
    wr_reg(WDSV_PERIOD_ADDR, 8'h00);
    chk_byte({7'h00, wdog_enabled}, 8'h01);
    // restart part-way, then time the full period from the restart
    repeat (1000) @(negedge ref_clk);
    unlock();
    // some count before power-down, so a lost count shows in the timing
    repeat (PRE_PD_CYC) @(negedge ref_clk);
    power_down_mode = 1'b1;
    repeat (FREEZE_CYC) @(negedge ref_clk);
    power_down_mode = 1'b0;
    chk_byte({7'h00, wdog_rst_pin}, 8'h00);
    to_exp = exp_timeout(0, 1) - PRE_PD_CYC;
    n = 0;
    while (wdog_rst_pin !== 1'b1 && n < to_exp + 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_cnt(n, to_exp - 6, to_exp + 6);
    chk_byte({7'h00, wdog_enabled}, 8'h00);
    n = 0;
    while (wdog_rst_pin === 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_cnt(n, WDSV_RST_PULSE_OSC, WDSV_RST_PULSE_OSC);
    // half-rate clock running, then reset while powered down
    wr_reg(WDSV_PERIOD_ADDR, 8'h05);
    wdog_clk_halfrate_sel = 1'b1;
    unlock();
    repeat (PRE_PD_CYC) @(negedge ref_clk);
    chk_byte({7'h00, wdog_enabled}, 8'h01);
    unlock();
    power_down_mode = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    power_down_mode = 1'b0;
    @(negedge ref_clk);
    chk_byte({7'h00, wdog_enabled}, 8'h00);
    rd_reg(WDSV_PERIOD_ADDR, rdv);
    chk_byte(rdv, 8'h00);
    complete_run();
  end

endmodule : wdsv_supervisor_tb
